// ==== rtl/daf_formatter.sv ====
/*
 * daf_formatter: output formatter of a two-channel sampled converter.
 * assumes both channel cores present a sample word and range flag on
 * the core clock, and that the encode clock is sampled as a pin.
 */
//
// Contract
// - one encode edge captures both channels
// - sixteen-bit words, bit 15 most significant
// - full rate: data change on falling clock
// - complement clock is always the inverse
// - full rate: each channel drives own flag
// - ddr single ended: two bits per pin
// - ddr: even bit while clock low
// - ddr: odd bit while clock high
// - ddr: data change on both clock edges
// - ddr shared flag: ch2 low, ch1 high
// - ddr differential: eight pairs per channel
// - differential: drive current and termination selectable
// - programmable clock phase delay versus data
// - range flag delayed like the data
// - strap config offers no ddr single ended
// - conversion starts on rising encode edge
`timescale 1ns/1ns
module daf_formatter
  import daf_pkg::*;
#(
  parameter int W     = daf_pkg::WORD_W,
  parameter int DEPTH = daf_pkg::PIPE_DEPTH
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // encode clock pin
  input  wire logic                          sample_clock_true,
  // converter core samples
  input  wire logic [W-1:0]                  ch1_sample,
  input  wire logic [W-1:0]                  ch2_sample,
  input  wire logic                          ch1_over,
  input  wire logic                          ch2_over,
  // configuration
  input  wire logic                          config_source_select,
  input  wire daf_pkg::daf_mode_e            serial_mode,
  input  wire logic                          strap_mode,
  input  wire logic [daf_pkg::PHASE_W-1:0]   clock_phase_delay,
  input  wire logic [daf_pkg::CURR_W-1:0]    serial_drive_current,
  input  wire logic                          serial_term_enable,
  // full rate outputs
  output logic [W-1:0]                       ch1_word_out,
  output logic [W-1:0]                       ch2_word_out,
  output logic                               ch1_range_flag,
  output logic                               ch2_range_flag,
  // ddr outputs
  output logic [W/2-1:0]                     ch1_ddr_pair_out,
  output logic [W/2-1:0]                     ch2_ddr_pair_out,
  output logic                               shared_range_flag,
  // forwarded clock
  output logic                               fwd_clock_true,
  output logic                               fwd_clock_comp,
  // driver control and active mode
  output daf_pkg::daf_mode_e                 active_mode,
  output logic [daf_pkg::CURR_W-1:0]         drive_current,
  output logic                               term_enable,
  output logic                               diff_enable
);
  import daf_pkg::*;

  localparam int DW = W + 1;
  localparam int DLY_LEN = (1 << PHASE_W) - 1;

  logic enc_s;
  logic enc_d;
  logic next_enc_d;
  logic enc_rise;
  logic enc_fall;

  daf_sync u_enc_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (sample_clock_true),
    .dout (enc_s)
  );

  // strap pins, two flops each
  logic strap_sel_s;
  logic strap_mode_s;

  daf_sync u_sel_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (config_source_select),
    .dout (strap_sel_s)
  );

  daf_sync u_strap_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (strap_mode),
    .dout (strap_mode_s)
  );

  // encode edges; one common capture for both channels
  assign enc_rise = enc_s & ~enc_d;
  assign enc_fall = ~enc_s & enc_d;

  // mode selection
  daf_mode_e mode_sel;
  daf_mode_e next_mode;
  logic [CURR_W-1:0] next_curr;
  logic next_term;
  logic next_diff;

  always_comb begin
    if (strap_sel_s) begin
      // strap: only full rate or differential ddr
      mode_sel = (strap_mode_s == STRAP_DDR_DIFF) ? DAF_MODE_DDR_DIFF : DAF_MODE_FULL;
    end else if (serial_mode == DAF_MODE_RSVD) begin
      mode_sel = DAF_MODE_FULL;
    end else begin
      mode_sel = serial_mode;
    end
    next_mode = active_mode;
    if (enc_rise) begin
      next_mode = mode_sel;
    end
    next_diff = (active_mode == DAF_MODE_DDR_DIFF);
    next_curr = strap_sel_s ? CURR_DEFAULT : serial_drive_current;
    next_term = ~strap_sel_s & serial_term_enable;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_mode   <= DAF_MODE_FULL;
      drive_current <= CURR_DEFAULT;
      term_enable   <= 1'h0;
      diff_enable   <= 1'h0;
    end else begin
      active_mode   <= next_mode;
      drive_current <= next_curr;
      term_enable   <= next_term;
      diff_enable   <= next_diff;
    end
  end

  // capture pipeline, flag travels with its word
  logic [DW-1:0] pipe1 [DEPTH];
  logic [DW-1:0] pipe2 [DEPTH];
  logic [DW-1:0] next_pipe1 [DEPTH];
  logic [DW-1:0] next_pipe2 [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_pipe
      if (gi == 0) begin : g_head
        always_comb begin
          next_pipe1[gi] = pipe1[gi];
          next_pipe2[gi] = pipe2[gi];
          if (enc_rise) begin
            next_pipe1[gi] = {ch1_over, ch1_sample};
            next_pipe2[gi] = {ch2_over, ch2_sample};
          end
        end
      end else begin : g_tail
        always_comb begin
          next_pipe1[gi] = pipe1[gi];
          next_pipe2[gi] = pipe2[gi];
          if (enc_rise) begin
            next_pipe1[gi] = pipe1[gi-1];
            next_pipe2[gi] = pipe2[gi-1];
          end
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pipe1[gi] <= '0;
          pipe2[gi] <= '0;
        end else begin
          pipe1[gi] <= next_pipe1[gi];
          pipe2[gi] <= next_pipe2[gi];
        end
      end
    end
  endgenerate

  logic [DW-1:0] out1;
  logic [DW-1:0] out2;
  assign out1 = pipe1[DEPTH-1];
  assign out2 = pipe2[DEPTH-1];

  // even and odd halves of each word
  logic [W/2-1:0] even1;
  logic [W/2-1:0] odd1;
  logic [W/2-1:0] even2;
  logic [W/2-1:0] odd2;
  generate
    for (gi = 0; gi < W/2; gi++) begin : g_split
      assign even1[gi] = out1[2*gi];
      assign odd1[gi]  = out1[2*gi+1];
      assign even2[gi] = out2[2*gi];
      assign odd2[gi]  = out2[2*gi+1];
    end
  endgenerate

  // output clock phase: low half after encode rise, high after fall
  logic phase_hi;
  logic next_phase_hi;
  logic [DLY_LEN-1:0] dly_sr;
  logic [DLY_LEN-1:0] next_dly_sr;
  logic [W-1:0] next_w1;
  logic [W-1:0] next_w2;
  logic next_f1;
  logic next_f2;
  logic [W/2-1:0] next_p1;
  logic [W/2-1:0] next_p2;
  logic next_sf;
  logic next_clk_t;

  always_comb begin
    next_enc_d    = enc_s;
    next_phase_hi = phase_hi;
    if (enc_rise) begin
      next_phase_hi = 1'h0;
    end else if (enc_fall) begin
      next_phase_hi = 1'h1;
    end
    // delay line for the forwarded clock
    next_dly_sr = {dly_sr[DLY_LEN-2:0], next_phase_hi};
    if (clock_phase_delay == '0) begin
      next_clk_t = next_phase_hi;
    end else begin
      next_clk_t = dly_sr[clock_phase_delay - 1'b1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enc_d          <= 1'h0;
      phase_hi       <= 1'h0;
      dly_sr         <= '0;
      fwd_clock_true <= 1'h0;
      fwd_clock_comp <= 1'h1;
    end else begin
      enc_d          <= next_enc_d;
      phase_hi       <= next_phase_hi;
      dly_sr         <= next_dly_sr;
      fwd_clock_true <= next_clk_t;
      fwd_clock_comp <= ~next_clk_t;
    end
  end

  // data pins, full rate or ddr by mode
  always_comb begin
    next_w1 = ch1_word_out;
    next_w2 = ch2_word_out;
    next_f1 = ch1_range_flag;
    next_f2 = ch2_range_flag;
    next_p1 = ch1_ddr_pair_out;
    next_p2 = ch2_ddr_pair_out;
    next_sf = shared_range_flag;
    if (active_mode == DAF_MODE_FULL) begin
      // word changes with the clock falling edge
      if (enc_rise) begin
        next_w1 = out1[W-1:0];
        next_w2 = out2[W-1:0];
        next_f1 = out1[W];
        next_f2 = out2[W];
      end
      next_p1 = '0;
      next_p2 = '0;
      next_sf = 1'h0;
    end else begin
      if (enc_rise) begin
        next_p1 = even1;
        next_p2 = even2;
        next_sf = out2[W];
      end else if (enc_fall) begin
        next_p1 = odd1;
        next_p2 = odd2;
        next_sf = out1[W];
      end
      next_w1 = '0;
      next_w2 = '0;
      next_f1 = 1'h0;
      next_f2 = 1'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch1_word_out      <= '0;
      ch2_word_out      <= '0;
      ch1_range_flag    <= 1'h0;
      ch2_range_flag    <= 1'h0;
      ch1_ddr_pair_out  <= '0;
      ch2_ddr_pair_out  <= '0;
      shared_range_flag <= 1'h0;
    end else begin
      ch1_word_out      <= next_w1;
      ch2_word_out      <= next_w2;
      ch1_range_flag    <= next_f1;
      ch2_range_flag    <= next_f2;
      ch1_ddr_pair_out  <= next_p1;
      ch2_ddr_pair_out  <= next_p2;
      shared_range_flag <= next_sf;
    end
  end
endmodule // daf_formatter

// ==== common/daf_pkg.sv ====
/*
 * daf_pkg: constants and types for the dual converter output formatter.
 * assumes a 125 MHz core clock and an encode clock sampled as a pin.
 */
package daf_pkg;
  localparam int WORD_W      = 16;
  localparam int PAIR_W      = WORD_W / 2;
  localparam int PIPE_DEPTH  = 4;
  localparam int PHASE_W     = 2;
  localparam int CURR_W      = 3;
  localparam logic [CURR_W-1:0] CURR_DEFAULT = 3'h4;

  typedef enum logic [1:0] {
    DAF_MODE_FULL,
    DAF_MODE_DDR_SE,
    DAF_MODE_DDR_DIFF,
    DAF_MODE_RSVD
  } daf_mode_e;

  localparam logic STRAP_DDR_DIFF = 1'h1;
endpackage

// ==== rtl/daf_sync.sv ====
/*
 * daf_sync: two-flop synchroniser for one level.
 * assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ns
module daf_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level
  input  wire logic din,
  output logic      dout
);
  logic stage1;
  logic next_stage1;
  logic next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'h0;
      dout   <= 1'h0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule // daf_sync

// ==== testbench/daf_formatter_props.sv ====
/* daf_formatter_props: port assertions of the formatter.
   assumes one core clock domain, async reset, 64 ns encode clock. */
`timescale 1ns/1ns
module daf_formatter_props
  import daf_pkg::*;
#(parameter int W = 16) (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst,
  // configuration and outputs
  input wire logic                        config_source_select,
  input wire logic [daf_pkg::PHASE_W-1:0] clock_phase_delay,
  input wire logic [W-1:0]                ch1_word_out,
  input wire logic                        ch1_range_flag,
  input wire logic [W/2-1:0]              ch1_ddr_pair_out,
  input wire logic                        fwd_clock_true,
  input wire logic                        fwd_clock_comp,
  input wire daf_pkg::daf_mode_e          active_mode,
  input wire logic [daf_pkg::CURR_W-1:0]  drive_current,
  input wire logic                        term_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_COMP: assert property (fwd_clock_comp == !fwd_clock_true)
    else $error("complement clock wrong");
  AST_FULL_EDGE: assert property (active_mode == DAF_MODE_FULL
    && clock_phase_delay == 2'h0 && $changed(ch1_word_out) |-> $fell(fwd_clock_true))
    else $error("word moved off falling clock");
  AST_FLAG_EDGE: assert property (active_mode == DAF_MODE_FULL
    && clock_phase_delay == 2'h0 && $changed(ch1_range_flag) |-> $fell(fwd_clock_true))
    else $error("flag moved apart from word");
  AST_DDR_EDGE: assert property (active_mode != DAF_MODE_FULL
    && clock_phase_delay == 2'h0 && $changed(ch1_ddr_pair_out) |-> $changed(fwd_clock_true))
    else $error("ddr pin moved off clock edge");
  AST_DDR_QUIET: assert property ((active_mode != DAF_MODE_FULL) [*2]
    |-> ch1_word_out == '0 && !ch1_range_flag) else $error("full pins busy in ddr");
  AST_STRAP_MODE: assert property (config_source_select [*8]
    ##1 config_source_select [*3] |=> active_mode != DAF_MODE_DDR_SE)
    else $error("strap gave ddr single ended");
  AST_STRAP_DRV: assert property (config_source_select [*8]
    |=> drive_current == CURR_DEFAULT && !term_enable) else $error("strap driver wrong");
  AST_FWD_HALF: assert property ($rose(fwd_clock_true)
    |=> fwd_clock_true [*2] ##[1:3] !fwd_clock_true) else $error("clock half period wrong");
  AST_PHASE_DLY1: assert property (active_mode == DAF_MODE_FULL
    && clock_phase_delay == 2'h1 && $changed(ch1_word_out) |-> ##1 $fell(fwd_clock_true))
    else $error("clock not delayed by one cycle");
  AST_PHASE_DLY2: assert property (active_mode == DAF_MODE_FULL
    && clock_phase_delay == 2'h2 && $changed(ch1_word_out) |-> ##2 $fell(fwd_clock_true))
    else $error("clock not delayed by two cycles");
endmodule // daf_formatter_props

bind daf_formatter daf_formatter_props #(.W(W)) u_props (
  .clk, .rst, .config_source_select, .clock_phase_delay, .ch1_word_out, .ch1_range_flag,
  .ch1_ddr_pair_out, .fwd_clock_true, .fwd_clock_comp, .active_mode, .drive_current,
  .term_enable
);

// ==== testbench/daf_rx_model.sv ====
/* daf_rx_model: logic receiver of the ddr output pins.
   assumes clk samples the forwarded clock four times a half. */
`timescale 1ns/1ns
module daf_rx_model (
  // clock
  input  wire logic       clk,
  // pins
  input  wire logic       fwd_clock_true,
  input  wire logic [7:0] ch1_ddr_pair_out,
  input  wire logic [7:0] ch2_ddr_pair_out,
  input  wire logic       shared_range_flag,
  // captured sample
  output logic [15:0]     rx_ch1,
  output logic [15:0]     rx_ch2,
  output logic            rx_flag1,
  output logic            rx_flag2
);
  logic [1:0] seen = 2'h0;
  // capture two cycles into each half, clear of data edges
  always @(posedge clk) begin
    seen <= {seen[0], fwd_clock_true};
    for (int i = 0; i < 8; i++) begin
      if (seen == 2'h1) begin
        rx_ch1[2*i+1] <= ch1_ddr_pair_out[i];
        rx_ch2[2*i+1] <= ch2_ddr_pair_out[i];
      end
      if (seen == 2'h2) begin
        rx_ch1[2*i] <= ch1_ddr_pair_out[i];
        rx_ch2[2*i] <= ch2_ddr_pair_out[i];
      end
    end
    if (seen == 2'h1) rx_flag1 <= shared_range_flag;
    if (seen == 2'h2) rx_flag2 <= shared_range_flag;
  end
endmodule // daf_rx_model

// ==== testbench/daf_formatter_tb.sv ====
/* daf_formatter_tb: mode tests of the output formatter.
   assumes the receiver model and the bound checker. */
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module daf_formatter_tb;
  import daf_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sample_clock_true = 1'b0;
  logic [15:0] ch1_sample = 16'h0000;
  logic [15:0] ch2_sample = 16'h0000;
  logic        ch1_over = 1'b0;
  logic        ch2_over = 1'b0;
  logic        config_source_select = 1'b0;
  daf_mode_e   serial_mode = DAF_MODE_FULL;
  logic        strap_mode = 1'b0;
  logic [1:0]  clock_phase_delay = 2'h0;
  logic [2:0]  serial_drive_current = 3'h0;
  logic        serial_term_enable = 1'b0;
  logic [15:0] ch1_word_out, ch2_word_out, rx_ch1, rx_ch2;
  logic [7:0]  ch1_ddr_pair_out, ch2_ddr_pair_out;
  logic        ch1_range_flag, ch2_range_flag, shared_range_flag, fwd_clock_true;
  logic        fwd_clock_comp, term_enable, diff_enable, rx_flag1, rx_flag2;
  daf_mode_e   active_mode;
  logic [2:0]  drive_current;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;

  daf_formatter uut (
    .clk, .rst, .sample_clock_true, .ch1_sample, .ch2_sample, .ch1_over, .ch2_over,
    .config_source_select, .serial_mode, .strap_mode, .clock_phase_delay,
    .serial_drive_current, .serial_term_enable, .ch1_word_out, .ch2_word_out,
    .ch1_range_flag, .ch2_range_flag, .ch1_ddr_pair_out, .ch2_ddr_pair_out,
    .shared_range_flag, .fwd_clock_true, .fwd_clock_comp, .active_mode, .drive_current,
    .term_enable, .diff_enable
  );
  daf_rx_model rx (
    .clk, .fwd_clock_true, .ch1_ddr_pair_out, .ch2_ddr_pair_out, .shared_range_flag,
    .rx_ch1, .rx_ch2, .rx_flag1, .rx_flag2
  );

  always #4 clk = ~clk;
  initial begin
    #3;
    forever #32 sample_clock_true = ~sample_clock_true;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches++;
      finish_test;
    end
  end

  // apply one setting, let the pipeline fill, compare at the pins
  task automatic run(input logic c, input daf_mode_e m, input logic st, input logic [1:0] d,
                     input logic [15:0] a, input logic [15:0] b, input logic x, input logic y);
    daf_mode_e em;
    @(negedge clk);
    config_source_select = c;
    serial_mode = m;
    strap_mode = st;
    clock_phase_delay = d;
    ch1_sample = a;
    ch2_sample = b;
    ch1_over = x;
    ch2_over = y;
    serial_drive_current = a[2:0];
    serial_term_enable = b[0];
    repeat (80) @(negedge clk);
    em = c ? (st ? DAF_MODE_DDR_DIFF : DAF_MODE_FULL) : (m == DAF_MODE_RSVD ? DAF_MODE_FULL : m);
    `CHK(active_mode, em)
    `CHK(diff_enable, em == DAF_MODE_DDR_DIFF)
    `CHK(drive_current, c ? CURR_DEFAULT : a[2:0])
    `CHK(term_enable, c ? 1'b0 : b[0])
    if (em == DAF_MODE_FULL) begin
      `CHK({ch1_word_out, ch2_word_out, ch1_range_flag, ch2_range_flag}, {a, b, x, y})
    end else begin
      `CHK({rx_ch1, rx_ch2, rx_flag1, rx_flag2}, {a, b, x, y})
    end
    $display("test done after %0d comparisons", tests_run);
  endtask

  // ch1 sample stands at hi and ch2 at ~hi while the encode pin is high, at lo and ~lo while low
  task automatic edge_run(input logic [15:0] hi, input logic [15:0] lo);
    run(1'b0, DAF_MODE_FULL, 1'b0, 2'h0, lo, lo, 1'b0, 1'b0);
    repeat (8) begin
      @(posedge sample_clock_true);
      @(negedge clk);
      ch1_sample = hi;
      ch2_sample = ~hi;
      @(negedge sample_clock_true);
      @(negedge clk);
      ch1_sample = lo;
      ch2_sample = ~lo;
    end
    `CHK({ch1_word_out, ch2_word_out}, {hi, ~hi})
    $display("edge test done after %0d comparisons", tests_run);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    run(1'b0, DAF_MODE_FULL, 1'b0, 2'h0, 16'hB4E1, 16'h2D78, 1'b1, 1'b0);
    run(1'b0, DAF_MODE_DDR_SE, 1'b0, 2'h0, 16'h8001, 16'h7FFE, 1'b0, 1'b1);
    run(1'b0, DAF_MODE_DDR_DIFF, 1'b0, 2'h1, 16'h5A3C, 16'hC3A5, 1'b1, 1'b0);
    run(1'b0, DAF_MODE_RSVD, 1'b0, 2'h2, 16'hFFFF, 16'h0000, 1'b1, 1'b1);
    run(1'b1, DAF_MODE_DDR_SE, 1'b0, 2'h1, 16'h1234, 16'hEDCB, 1'b0, 1'b1);
    run(1'b1, DAF_MODE_DDR_SE, 1'b1, 2'h0, 16'h0F0F, 16'hF0F0, 1'b1, 1'b0);
    run(1'b0, DAF_MODE_DDR_SE, 1'b0, 2'h0, 16'h6B2D, 16'h94D2, 1'b1, 1'b1);
    edge_run(16'hA55A, 16'h3CC3);
    finish_test;
  end
endmodule // daf_formatter_tb
